// file: ihd_consts.vh
// Purpose: Constants for the ingress header decoder
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: Included by ihd_decoder.v
`ifndef IHD_CONSTS_VH
`define IHD_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IHD_OFF_CFG 8'h00
`define IHD_OFF_FILTER 8'h04
`define IHD_OFF_MAP0 8'h08
`define IHD_OFF_MAP1 8'h0C
`define IHD_OFF_MAP2 8'h10
`define IHD_OFF_MAP3 8'h14
`define IHD_OFF_STATUS 8'h18
`define IHD_OFF_PARCNT 8'h1C
`define IHD_OFF_DROPCNT 8'h20
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define IHD_CFG_MODE512 0
`define IHD_CFG_PAIRED 1
`define IHD_CFG_BEEN 2
`define IHD_CFG_NPRIO_LO 4
`define IHD_CFG_NPRIO_HI 5
`define IHD_CFG_RST 32'h0000_0030
`define IHD_FILTER_RST 32'h0000_0000
// ----------------------------------------
// Qualifier byte fields
// ----------------------------------------
`define IHD_Q_EXT 0
`define IHD_Q_PAR 1
`define IHD_Q_PROT_LO 2
`define IHD_Q_PROT_HI 3
`define IHD_Q_BE 4
`define IHD_Q_GRANT 5
`define IHD_Q_PRIO_LO 6
`define IHD_Q_PRIO_HI 7
// ----------------------------------------
// Protection codes and flywheel limits
// ----------------------------------------
`define IHD_PROT_IDLE 2'h0
`define IHD_PROT_BACKUP 2'h1
`define IHD_PROT_ACTIVE 2'h2
`define IHD_SUB_LAST 3'h4
`endif

// file: ihd_decoder.v
// Purpose: Decode ingress packet headers and map destinations to physical ports
// Assumes: Header bytes arrive at most one per cycle, qualified by hdrByteValid, with a start strobe on the qualifier
// Notes: Registers over APB, zero wait states
//
// Function
// - Qualifier byte field layout is fixed
// - Extended bit selects lower or upper half
// - Protection 00 is idle, no filtering
// - Backup filters bitmap, active leaves it
// - Route filtered bitmap, drop if zero
// - Control detected before filter is applied
// - All-zero bitmap means control packet
// - Best-effort flag only when discard enabled
// - Drop best-effort only, never guaranteed traffic
// - High channel bit 5 is send grant
// - Low channel bit 5 is subport grant
// - Priority bits 6:7, 00 highest
// - Control packets ignore priority field
// - Each set bit enqueues to that port
// - Logical to physical mapping within subswitch
// - 256 mode: first byte, half by select
// - 512 mode: two bytes, half by select
// - Second bitmap byte only in 512 mode
// - Paired mode: bit n to 2n, 2n+1; the code applies it in 256 mode only
// - Grant priority flywheel advances and wraps
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "ihd_consts.vh"

module ihd_decoder #(
  parameter PORTS = 32,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Header byte stream
  input wire hdrStart,
  input wire hdrByteValid,
  input wire [7:0] hdrByte,
  input wire highChannel,
  input wire congested,
  // Decoded packet
  output reg decValid,
  output reg [PORTS-1:0] destPorts,
  output reg [1:0] pktPriority,
  output reg isControl,
  output reg isIdle,
  output reg dropPkt,
  output reg parityErr,
  // Grant report
  output reg grantValid,
  output reg grantBit,
  output reg grantIsSubport,
  output reg [1:0] grantPrio,
  output reg [2:0] grantSubType
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_B1 = 3'h2;
  localparam [2:0] ST_B2 = 3'h4;

  // ----------------------------------------
  // Configuration registers, counters and flywheels
  // ----------------------------------------
  reg [31:0] cfg_q;
  reg [31:0] filter_q;
  reg [2:0] map_q [0:PORTS-1];
  reg [CNT_W-1:0] parCnt_q;
  reg [CNT_W-1:0] dropCnt_q;
  reg [1:0] prioWheel_q;
  reg [2:0] subWheel_q;

  wire mode512 = cfg_q[`IHD_CFG_MODE512];
  wire paired = cfg_q[`IHD_CFG_PAIRED];
  wire beEnable = cfg_q[`IHD_CFG_BEEN];
  wire [1:0] numPrio = cfg_q[`IHD_CFG_NPRIO_HI:`IHD_CFG_NPRIO_LO];

  wire wrEn = psel & penable & pwrite;
  wire rdSetup = psel & ~penable & ~pwrite;
  wire addrOk = (paddr[1:0] == 2'h0) && (paddr <= `IHD_OFF_DROPCNT);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrOk;

  integer kb, kr, km;

  // ----------------------------------------
  // Header capture state
  // ----------------------------------------
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] qual_q;
  reg [7:0] first_q;
  reg [1:0] capPrio_q;
  reg [2:0] capSub_q;
  reg capHigh_q;
  reg doDecode;
  reg [7:0] secondByte;

  always @* begin
    state_d = state_q;
    doDecode = 1'b0;
    secondByte = 8'h00;
    case (state_q)
      ST_WAIT: begin
        state_d = ST_WAIT;
      end
      ST_B1: begin
        if (hdrByteValid) begin
          if (mode512) begin
            state_d = ST_B2;
          end else begin
            state_d = ST_WAIT;
            doDecode = 1'b1;
          end
        end
      end
      ST_B2: begin
        if (hdrByteValid) begin
          state_d = ST_WAIT;
          doDecode = 1'b1;
          secondByte = hdrByte;
        end
      end
      default: begin
        state_d = ST_WAIT;
      end
    endcase
    // A fresh start always restarts capture
    if (hdrStart && hdrByteValid) begin
      state_d = ST_B1;
      doDecode = 1'b0;
    end
  end

  // ----------------------------------------
  // Bitmap assembly, filter and mapping
  // ----------------------------------------
  wire [7:0] firstByte = (state_q == ST_B1) ? hdrByte : first_q;
  wire extSel = qual_q[`IHD_Q_EXT];
  wire [1:0] prot = qual_q[`IHD_Q_PROT_HI:`IHD_Q_PROT_LO];
  reg [31:0] logBitmap;
  reg [31:0] filtBitmap;
  reg [31:0] mapped;
  reg [31:0] phys;
  reg parityBad;
  reg isCtl;
  reg isIdl;
  reg beDrop;
  reg drop;

  always @* begin
    logBitmap = 32'h0000_0000;
    if (mode512) begin
      if (extSel) begin
        logBitmap = {secondByte, firstByte, 16'h0000};
      end else begin
        logBitmap = {16'h0000, secondByte, firstByte};
      end
    end else begin
      if (extSel) begin
        logBitmap = {16'h0000, firstByte, 8'h00};
      end else begin
        logBitmap = {24'h00_0000, firstByte};
      end
    end
    // Even parity over all header bytes, parity bit included
    parityBad = ^{qual_q, firstByte, (mode512 ? secondByte : 8'h00)};
    isIdl = (prot == `IHD_PROT_IDLE);
    // Control is judged on the raw bitmap, before filtering
    isCtl = ~isIdl & (logBitmap == 32'h0000_0000);
    if (prot == `IHD_PROT_BACKUP) begin
      filtBitmap = logBitmap & ~filter_q;
    end else begin
      filtBitmap = logBitmap;
    end
    if (isIdl) begin
      filtBitmap = 32'h0000_0000;
    end
    mapped = 32'h0000_0000;
    for (kb = 0; kb < PORTS; kb = kb + 1) begin
      if (filtBitmap[kb]) begin
        mapped[{kb[4:3], map_q[kb]}] = 1'b1;
      end
    end
    phys = mapped;
    if (paired && !mode512) begin
      for (kb = 0; kb < 16; kb = kb + 1) begin
        phys[2*kb] = mapped[kb];
        phys[2*kb+1] = mapped[kb];
      end
    end
    // Discard only packets flagged best effort, never guaranteed ones
    beDrop = beEnable & qual_q[`IHD_Q_BE] & congested & ~isCtl & ~isIdl;
    drop = parityBad | beDrop | (~isCtl & ~isIdl & (filtBitmap == 32'h0000_0000));
  end

  // ----------------------------------------
  // Capture and flywheels
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_WAIT;
      qual_q <= 8'h00;
      first_q <= 8'h00;
      capPrio_q <= 2'h0;
      capSub_q <= 3'h0;
      capHigh_q <= 1'b0;
      prioWheel_q <= 2'h0;
      subWheel_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (hdrStart && hdrByteValid) begin
        qual_q <= hdrByte;
        capPrio_q <= prioWheel_q;
        capSub_q <= subWheel_q;
        capHigh_q <= highChannel;
        // One header start per packet cycle
        if (prioWheel_q >= numPrio) begin
          prioWheel_q <= 2'h0;
          if (subWheel_q >= `IHD_SUB_LAST) begin
            subWheel_q <= 3'h0;
          end else begin
            subWheel_q <= subWheel_q + 3'h1;
          end
        end else begin
          prioWheel_q <= prioWheel_q + 2'h1;
        end
      end
      if (state_q == ST_B1 && hdrByteValid && !hdrStart) begin
        first_q <= hdrByte;
      end
    end
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      decValid <= 1'b0;
      destPorts <= {PORTS{1'b0}};
      pktPriority <= 2'h0;
      isControl <= 1'b0;
      isIdle <= 1'b0;
      dropPkt <= 1'b0;
      parityErr <= 1'b0;
      grantValid <= 1'b0;
      grantBit <= 1'b0;
      grantIsSubport <= 1'b0;
      grantPrio <= 2'h0;
      grantSubType <= 3'h0;
    end else begin
      decValid <= doDecode;
      grantValid <= doDecode & ~parityBad;
      parityErr <= doDecode & parityBad;
      if (doDecode) begin
        destPorts <= drop ? {PORTS{1'b0}} : phys[PORTS-1:0];
        // Control packets carry no priority
        pktPriority <= isCtl ? 2'h0 : qual_q[`IHD_Q_PRIO_HI:`IHD_Q_PRIO_LO];
        isControl <= isCtl;
        isIdle <= isIdl;
        dropPkt <= drop;
        grantBit <= qual_q[`IHD_Q_GRANT];
        grantIsSubport <= ~capHigh_q;
        grantPrio <= capPrio_q;
        grantSubType <= capSub_q;
      end
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  wire dropWr = wrEn && (paddr == `IHD_OFF_DROPCNT);
  wire parWr = wrEn && (paddr == `IHD_OFF_PARCNT);
  wire doDrop = doDecode & drop;
  wire doPar = doDecode & parityBad;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      parCnt_q <= {CNT_W{1'b0}};
      dropCnt_q <= {CNT_W{1'b0}};
    end else begin
      // A count event in the clearing cycle is kept
      if (doPar) begin
        parCnt_q <= parWr ? {{(CNT_W-1){1'b0}}, 1'b1} : parCnt_q + 1'b1;
      end else if (parWr) begin
        parCnt_q <= {CNT_W{1'b0}};
      end
      if (doDrop) begin
        dropCnt_q <= dropWr ? {{(CNT_W-1){1'b0}}, 1'b1} : dropCnt_q + 1'b1;
      end else if (dropWr) begin
        dropCnt_q <= {CNT_W{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `IHD_CFG_RST;
      filter_q <= `IHD_FILTER_RST;
      for (kr = 0; kr < PORTS; kr = kr + 1) begin
        map_q[kr] <= kr[2:0];
      end
    end else if (wrEn) begin
      case (paddr)
        `IHD_OFF_CFG: cfg_q <= {26'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
        `IHD_OFF_FILTER: filter_q <= pwdata;
        `IHD_OFF_MAP0, `IHD_OFF_MAP1, `IHD_OFF_MAP2, `IHD_OFF_MAP3: begin
          for (kr = 0; kr < 8; kr = kr + 1) begin
            map_q[{paddr[3:2] + 2'h2, kr[2:0]}] <= pwdata[4*kr +: 3];
          end
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // Read data is latched in setup so the access phase needs no wait
  reg [31:0] rdMux;
  reg [4:0] mapBase;
  always @* begin
    rdMux = 32'h0000_0000;
    mapBase = {paddr[3:2] + 2'h2, 3'h0};
    case (paddr)
      `IHD_OFF_CFG: rdMux = cfg_q;
      `IHD_OFF_FILTER: rdMux = filter_q;
      `IHD_OFF_MAP0, `IHD_OFF_MAP1, `IHD_OFF_MAP2, `IHD_OFF_MAP3: begin
        for (km = 0; km < 8; km = km + 1) begin
          rdMux[4*km +: 3] = map_q[mapBase + km[4:0]];
        end
      end
      `IHD_OFF_STATUS: rdMux = {24'h00_0000, 1'b0, state_q, 1'b0, subWheel_q} |
                               {22'h0, prioWheel_q, 8'h00};
      `IHD_OFF_PARCNT: rdMux = {{(32-CNT_W){1'b0}}, parCnt_q};
      `IHD_OFF_DROPCNT: rdMux = {{(32-CNT_W){1'b0}}, dropCnt_q};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= rdMux;
    end
  end

endmodule // ihd_decoder

// file: ihd_props.sv
// Purpose: Port checker for the ingress header decoder
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every decoder instance
`timescale 1ns/10ps
`include "ihd_consts.vh"
module ihd_props #(
  parameter PORTS = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Decode results
  input wire hdrByteValid,
  input wire decValid,
  input wire [PORTS-1:0] destPorts,
  input wire [1:0] pktPriority,
  input wire isControl,
  input wire isIdle,
  input wire dropPkt,
  input wire parityErr,
  input wire grantValid,
  input wire [2:0] grantSubType
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----
  // Assertions
  // ----
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_decode: assert property (psel && penable |->
    pslverr == (paddr > 8'h20 || paddr[1:0] != 2'b00)) else $error("pslverr wrong");
  a_err_rdzero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_dec_source: assert property (decValid |-> $past(hdrByteValid) || $past(hdrByteValid, 2))
    else $error("decode without header byte");
  a_dec_pulse: assert property (decValid |=> !decValid) else $error("decValid too long");
  a_idle_quiet: assert property (
    decValid && isIdle |-> destPorts == '0 && !dropPkt && !isControl)
    else $error("idle packet routed");
  a_ctrl_noprio: assert property (
    decValid && isControl |-> pktPriority == 2'h0 && destPorts == '0)
    else $error("control packet priority");
  a_drop_nodest: assert property (
    decValid && dropPkt |-> destPorts == '0) else $error("dropped packet routed");
  a_parity_drop: assert property (
    parityErr |-> decValid && dropPkt) else $error("parity error not dropped");
  a_grant_good: assert property (
    grantValid |-> decValid && !parityErr) else $error("grant from bad header");
  a_sub_range: assert property (
    grantValid |-> grantSubType <= `IHD_SUB_LAST) else $error("subport flywheel range");
  c_control: cover property (decValid && isControl);
  c_drop: cover property (decValid && dropPkt);
  c_grant: cover property (grantValid);
endmodule // ihd_props
bind ihd_decoder ihd_props #(.PORTS(PORTS)) i_ihd_props (.ref_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pready, .prdata, .pslverr, .hdrByteValid, .decValid, .destPorts,
  .pktPriority, .isControl, .isIdle, .dropPkt, .parityErr, .grantValid, .grantSubType);

// file: ihd_adapter.sv
// Purpose: Attached adapter model sending ingress headers
// Assumes: Decoder samples header bytes at rising edges
// Notes: Released byte lane toggles so stale data never passes for a byte
`timescale 1ns/10ps
module ihd_adapter (
  // Clock
  input wire ref_clk,
  // Header stream
  output logic hdrStart,
  output logic hdrByteValid,
  output logic [7:0] hdrByte,
  output logic highChannel
);
  initial begin
    hdrStart = 1'b0;
    hdrByteValid = 1'b0;
    hdrByte = 8'h00;
    highChannel = 1'b0;
  end
  // Caller sets every field except the parity bit, which send computes; one port half per packet
  task automatic send(input logic [23:0] h, input int n, input logic hi, input logic bad,
    input int gap);
    logic [23:0] m;
    m = h;
    m[1] = 1'b0;
    if (n < 3) begin
      m[23:16] = 8'h00;
    end
    m[1] = ^m ^ bad;
    for (int i = 0; i < n; i++) begin
      repeat ((i > 0) ? gap : 0) begin
        @(posedge ref_clk);
        hdrStart <= 1'b0;
        hdrByteValid <= 1'b0;
        hdrByte <= ~hdrByte;
      end
      @(posedge ref_clk);
      hdrStart <= (i == 0);
      hdrByteValid <= 1'b1;
      hdrByte <= m[8*i +: 8];
      highChannel <= hi;
    end
    @(posedge ref_clk);
    hdrStart <= 1'b0;
    hdrByteValid <= 1'b0;
    hdrByte <= ~hdrByte;
  endtask
endmodule // ihd_adapter

// file: tb_top.sv
// Purpose: Self-checking bench for the ingress header decoder
// Assumes: APB and header stream driven right after rising edges
// Notes: Grant flywheels tracked from a packet count since reset
`timescale 1ns/10ps
`include "ihd_consts.vh"
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic congested = 1'b0;
  logic mode512 = 1'b0;
  wire pready, pslverr, hdrStart, hdrByteValid, highChannel, decValid, isControl, isIdle;
  wire dropPkt, parityErr, grantValid, grantBit, grantIsSubport;
  wire [31:0] prdata, destPorts;
  wire [7:0] hdrByte;
  wire [1:0] pktPriority, grantPrio;
  wire [2:0] grantSubType;
  int error_cnt = 0;
  int check_count = 0;
  int pktCnt = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  ihd_decoder i_ihd_decoder (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .hdrStart, .hdrByteValid, .hdrByte, .highChannel,
    .congested, .decValid, .destPorts, .pktPriority, .isControl, .isIdle, .dropPkt,
    .parityErr, .grantValid, .grantBit, .grantIsSubport, .grantPrio, .grantSubType);
  ihd_adapter i_ihd_adapter (.ref_clk, .hdrStart, .hdrByteValid, .hdrByte, .highChannel);
  task automatic chkReg(input string n, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkDec(input string n, input logic [46:0] e, input logic [46:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [32:0] r);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chkReg($sformatf("reg_%h", a), e, r);
  endtask
  // Flags f: priority, control, idle, drop
  task automatic pkt(input logic [23:0] h, input logic bad, input logic [31:0] dst,
    input logic [4:0] f);
    logic hi;
    int t;
    hi = pktCnt[0];
    i_ihd_adapter.send(h, mode512 ? 3 : 2, hi, bad, (pktCnt % 3 == 2) ? 1 : 0);
    t = 0;
    #1;
    while (decValid !== 1'b1 && t < 4) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    chkDec("decode",
      {1'b1, dst, f, bad, ~bad, h[5], ~hi, 2'(pktCnt % 4), 3'((pktCnt / 4) % 5)},
      {decValid, destPorts, pktPriority, isControl, isIdle, dropPkt, parityErr, grantValid,
      grantBit, grantIsSubport, grantPrio, grantSubType});
    pktCnt++;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 130 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    congested <= 1'b1;
    rd(`IHD_OFF_CFG, {1'b0, `IHD_CFG_RST});
    rd(`IHD_OFF_FILTER, {1'b0, `IHD_FILTER_RST});
    rd(`IHD_OFF_MAP0, 33'h0_7654_3210);
    rd(8'h24, 33'h1_0000_0000);
    pkt(24'h00A5A8, 1'b0, 32'h0000_00A5, 5'b10000);
    pkt(24'h00FF08, 1'b0, 32'h0000_00FF, 5'b00000);
    pkt(24'h00FF09, 1'b0, 32'h0000_FF00, 5'b00000);
    pkt(24'h0000C8, 1'b0, 32'h0, 5'b00100);
    pkt(24'h005A00, 1'b0, 32'h0, 5'b00010);
    wr(`IHD_OFF_FILTER, 32'h0000_000F);
    pkt(24'h00FF04, 1'b0, 32'h0000_00F0, 5'b00000);
    pkt(24'h000F04, 1'b0, 32'h0, 5'b00001);
    pkt(24'h000F08, 1'b0, 32'h0000_000F, 5'b00000);
    wr(`IHD_OFF_FILTER, 32'h0);
    pkt(24'h000118, 1'b0, 32'h0000_0001, 5'b00000);
    wr(`IHD_OFF_CFG, 32'h0000_0034);
    pkt(24'h000118, 1'b0, 32'h0, 5'b00001);
    pkt(24'h000108, 1'b0, 32'h0000_0001, 5'b00000);
    @(posedge ref_clk);
    congested <= 1'b0;
    pkt(24'h000118, 1'b0, 32'h0000_0001, 5'b00000);
    @(posedge ref_clk);
    congested <= 1'b1;
    wr(`IHD_OFF_CFG, `IHD_CFG_RST);
    pkt(24'h000108, 1'b1, 32'h0, 5'b00001);
    rd(`IHD_OFF_PARCNT, 33'h0_0000_0001);
    rd(`IHD_OFF_DROPCNT, 33'h0_0000_0003);
    wr(`IHD_OFF_PARCNT, 32'h0);
    rd(`IHD_OFF_PARCNT, 33'h0);
    wr(`IHD_OFF_MAP0, 32'h7654_3211);
    pkt(24'h000108, 1'b0, 32'h0000_0002, 5'b00000);
    wr(`IHD_OFF_MAP0, 32'h7654_3210);
    wr(`IHD_OFF_MAP1, 32'h7654_3201);
    rd(`IHD_OFF_MAP1, 33'h0_7654_3201);
    pkt(24'h000109, 1'b0, 32'h0000_0200, 5'b00000);
    wr(`IHD_OFF_MAP1, 32'h7654_3210);
    wr(`IHD_OFF_CFG, 32'h0000_0032);
    pkt(24'h000808, 1'b0, 32'h0000_00C0, 5'b00000);
    wr(`IHD_OFF_CFG, 32'h0000_0031);
    mode512 = 1'b1;
    pkt(24'h800109, 1'b0, 32'h8001_0000, 5'b00000);
    pkt(24'h040208, 1'b0, 32'h0000_0402, 5'b00000);
    rd(`IHD_OFF_STATUS,
      {1'b0, 22'h0, 2'(pktCnt % 4), 1'b0, 3'h1, 1'b0, 3'((pktCnt / 4) % 5)});
    summarize();
  end
endmodule // tb_top
